/* File: hdl/pmp_regs.vh */
`ifndef PMP_REGS_VH
`define PMP_REGS_VH
// register indices; byte address is four times the index
`define PMP_IDX_P1_FSEL     16'hFFC8
`define PMP_IDX_PIN_OPT     16'hFFC9
`define PMP_IDX_P3_FSEL     16'hFFCA
`define PMP_IDX_P1_DATA     16'hFFD4
`define PMP_IDX_P3_DATA     16'hFFD6
`define PMP_IDX_P1_PULLUP   16'hFFE0
`define PMP_IDX_P3_PULLUP   16'hFFE1
`define PMP_IDX_P1_DIR      16'hFFE4
`define PMP_IDX_P3_DIR      16'hFFE6
// reset values
`define PMP_RST_PIN_OPT     8'hD8
`define PMP_RST_P3          8'h00
`define PMP_RST_P1          8'h00
`define PMP_RST_P3_FSEL     8'h00
// fixed bits of the shared pin-option register
`define PMP_PIN_OPT_FIXED   8'hD8
`define PMP_PIN_OPT_WMASK   8'h27
// port 1 function select: fixed ones and implemented bits
`define PMP_P1_FSEL_ONES    8'h42
`define PMP_P1_MASK         8'h98
// port 3 function select writable bits
`define PMP_P3_FSEL_WMASK   8'hC7
// bit positions
`define PMP_BIT_P17         7
`define PMP_BIT_P14         4
`define PMP_BIT_P13         3
`define PMP_BIT_OPEN_DRAIN  5
// direction registers are write-only and read back as ones
`define PMP_DIR_READ        8'hFF
// operating mode codes on mode_i
`define PMP_MODE_ACTIVE     3'h0
`define PMP_MODE_SUBACTIVE  3'h1
`define PMP_MODE_SLEEP      3'h2
`define PMP_MODE_SUBSLEEP   3'h3
`define PMP_MODE_STANDBY    3'h4
`define PMP_MODE_WATCH      3'h5
`endif

/* File: hdl/pmp_port_ctrl.v */
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - pin 14 select: interrupt-4, converter trigger
// - pin 13 select gives capture-G input
// - reset hi-z, port 1 holds in sleep, active works
// - port 1 standby pull-up pin drives high
// - pull-up on only for input with enable
// - port 1 pull-ups off after reset
// - port 3 has eight bidirectional pins
// - port 3 read: latch outputs, pin inputs
// - port 3 latch clears on reset
// - port 3 data register, read/write, zero
// - port 3 direction write-only, resets zero
// - port 3 pull-up register, resets zero
// - pin-option register resets to D8
// - port 3 function-select register read/write
// - port 1 direction: one output, zero input
// - port 1 direction reads all ones
// - port 1 read: latch outputs, pin inputs
`include "pmp_regs.vh"
module pmp_port_ctrl #(
  parameter ADR_W = 18               // byte address width
) (
  input  wire             clk_i,
  input  wire             rst_i,
  // classic wishbone slave
  input  wire             cyc_i,
  input  wire             stb_i,
  input  wire             we_i,
  input  wire [ADR_W-1:0] adr_i,
  input  wire [3:0]       sel_i,
  input  wire [31:0]      dat_i,
  output wire [31:0]      dat_o,
  output wire             ack_o,
  // operating mode and peripheral controls
  input  wire [2:0]       mode_i,
  input  wire [2:0]       timer_f_clock_sel_i,
  input  wire             converter_trigger_enable_i,
  // port 1 pins (bits 7, 4, 3 used)
  input  wire [7:0]       p1_in_i,
  output wire [7:0]       p1_out_o,
  output wire [7:0]       p1_oe_o,
  output wire [7:0]       p1_pu_o,
  // port 3 pins
  input  wire [7:0]       p3_in_i,
  output wire [7:0]       p3_out_o,
  output wire [7:0]       p3_oe_o,
  output wire [7:0]       p3_pu_o,
  // peripheral inputs taken from port 1 pins, idle high
  output wire             p17_interrupt_select_pin_o,
  output wire             p14_interrupt_select_pin_o,
  output wire             timer_f_event_input_o,
  output wire             converter_ext_trigger_o,
  output wire             capture_g_input_o
);

  // register file; port 1 keeps only bits 7, 4 and 3,
  // so its missing bits always read back as zero
  // (the function-select read adds its two fixed ones, the direction read gives all ones)
  reg  [7:0]  p1_data_reg;            // port 1 data latch
  reg  [7:0]  p1_dir_reg;             // port 1 direction
  reg  [7:0]  p1_pu_reg;              // port 1 pull-up enable
  reg  [7:0]  p1_fsel_reg;            // port 1 function select
  reg  [7:0]  pin_opt_reg;            // shared pin options
  reg  [7:0]  p3_fsel_reg;            // port 3 function select
  reg  [7:0]  p3_data_reg;            // port 3 data latch
  reg  [7:0]  p3_pu_reg;              // port 3 pull-up enable
  reg  [7:0]  p3_dir_reg;             // port 3 direction
  // bus answer; read data is captured when the request is taken,
  // so it stands unchanged through the whole ack cycle
  reg         ack_reg;                // one-cycle acknowledge
  reg  [7:0]  rdata_reg;              // captured read data
  reg  [7:0]  rdata_next;             // read mux
  // port 1 pin drive, held through sleep
  // next values come from the mode process below;
  // sleep simply keeps these registers as they are
  reg  [7:0]  p1_out_reg;
  reg  [7:0]  p1_oe_reg;
  reg  [7:0]  p1_pu_out_reg;
  reg  [7:0]  p1_out_next;
  reg  [7:0]  p1_oe_next;
  reg  [7:0]  p1_pu_out_next;
  // port 3 pin drive; this port ignores the operating mode,
  // so its pins keep working through sleep and standby
  reg  [7:0]  p3_out_reg;
  reg  [7:0]  p3_oe_reg;
  reg  [7:0]  p3_pu_out_reg;
  // peripheral inputs; each one rests high while its pin
  // is general i/o, so a peripheral never sees a false edge
  reg         p17_interrupt_select_reg;
  reg         p14_interrupt_select_reg;
  reg         tmf_reg;
  reg         converter_ext_trigger_reg;
  reg         capg_reg;

  // decode helpers shared by the read mux and the write path
  wire        req     = cyc_i & stb_i;     // live request
  // a write lands on the edge that samples ack high, while the
  // master still holds address and data; only byte lane 0 counts
  wire        wr_take = req & we_i & ack_reg & sel_i[0];
  wire [15:0] idx     = adr_i[17:2];        // register index
  wire [7:0]  wd      = dat_i[7:0];
  // a set function-select bit forces the pin to input, except a pulled-up port 1 pin in standby or watch
  wire [7:0]  p1_gpio = ~p1_fsel_reg;       // ones where the pin is gpio
  wire [7:0]  p1_dir_eff = p1_dir_reg & p1_gpio;
  wire [7:0]  p3_dir_eff = p3_dir_reg & ~p3_fsel_reg;

  // pull-up is on only for an input with its enable set;
  // port 1 callers pass the raw direction bit, so a port 1 pin whose direction
  // is one never gets its pull-up, whatever function it serves; port 3 passes p3_dir_eff
  function [7:0] pmp_pullup;
    input [7:0] dir;
    input [7:0] pu;
    begin
      pmp_pullup = ~dir & pu;
    end
  endfunction

  // port read: latch for outputs, pin level for inputs
  // shared by both ports; port 1 masks its missing bits afterwards
  function [7:0] pmp_port_read;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pins;
    begin
      pmp_port_read = (dir & latch) | (~dir & pins);
    end
  endfunction

  // read mux; unmapped addresses answer zero
  // the write-only direction registers answer all ones;
  // trade-off: data is sampled when the request is taken,
  // so a pin change during the ack cycle shows on the next read
  always @* begin
    case (idx)
      `PMP_IDX_P1_DATA:   rdata_next = pmp_port_read(p1_dir_reg, p1_data_reg,
                                       p1_in_i) & `PMP_P1_MASK;
      `PMP_IDX_P1_DIR:    rdata_next = `PMP_DIR_READ;
      `PMP_IDX_P1_PULLUP: rdata_next = p1_pu_reg;
      `PMP_IDX_P1_FSEL:   rdata_next = p1_fsel_reg | `PMP_P1_FSEL_ONES;
      `PMP_IDX_PIN_OPT:   rdata_next = pin_opt_reg;
      `PMP_IDX_P3_FSEL:   rdata_next = p3_fsel_reg;
      `PMP_IDX_P3_DATA:   rdata_next = pmp_port_read(p3_dir_reg, p3_data_reg,
                                       p3_in_i);
      `PMP_IDX_P3_PULLUP: rdata_next = p3_pu_reg;
      `PMP_IDX_P3_DIR:    rdata_next = `PMP_DIR_READ;
      default:            rdata_next = 8'h00;
    endcase
  end

  // ack one cycle after the request, then drop for a cycle
  // a held request is answered every other cycle, never back to back;
  // there is no error answer: unmapped or masked writes are acked too
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= req & ~ack_reg;
      // capture only on the edge that takes the request
      if (req & ~ack_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // register writes land on the acknowledging edge
  // reserved bits are masked here so reads never show them
  always @(posedge clk_i) begin
    if (rst_i) begin
      p1_data_reg <= `PMP_RST_P1;
      p1_dir_reg  <= `PMP_RST_P1;
      p1_pu_reg   <= `PMP_RST_P1;
      p1_fsel_reg <= `PMP_RST_P1;
      pin_opt_reg <= `PMP_RST_PIN_OPT;
      p3_fsel_reg <= `PMP_RST_P3_FSEL;
      p3_data_reg <= `PMP_RST_P3;
      p3_pu_reg   <= `PMP_RST_P3;
      p3_dir_reg  <= `PMP_RST_P3;
    end else if (wr_take) begin
      case (idx)
        `PMP_IDX_P1_DATA:   p1_data_reg <= wd & `PMP_P1_MASK;
        `PMP_IDX_P1_DIR:    p1_dir_reg  <= wd & `PMP_P1_MASK;
        `PMP_IDX_P1_PULLUP: p1_pu_reg   <= wd & `PMP_P1_MASK;
        `PMP_IDX_P1_FSEL:   p1_fsel_reg <= wd & `PMP_P1_MASK;
        // fixed ones stay set whatever is written
        `PMP_IDX_PIN_OPT:   pin_opt_reg <= (wd & `PMP_PIN_OPT_WMASK) |
                                           `PMP_PIN_OPT_FIXED;
        `PMP_IDX_P3_FSEL:   p3_fsel_reg <= wd & `PMP_P3_FSEL_WMASK;
        `PMP_IDX_P3_DATA:   p3_data_reg <= wd;
        `PMP_IDX_P3_PULLUP: p3_pu_reg   <= wd;
        `PMP_IDX_P3_DIR:    p3_dir_reg  <= wd;
        default: begin
        end
      endcase
    end
  end

  // port 1 pin state per operating mode
  // defaults hold the pins, which is all sleep needs;
  // a mode change reaches the pins one clock later
  always @* begin
    p1_out_next    = p1_out_reg;
    p1_oe_next     = p1_oe_reg;
    p1_pu_out_next = p1_pu_out_reg;
    case (mode_i)
      `PMP_MODE_ACTIVE, `PMP_MODE_SUBACTIVE: begin
        // normal: gpio direction, pull-up on inputs
        p1_out_next    = p1_data_reg & p1_dir_eff;
        p1_oe_next     = p1_dir_eff;
        p1_pu_out_next = pmp_pullup(p1_dir_reg, p1_pu_reg);
      end
      `PMP_MODE_SLEEP, `PMP_MODE_SUBSLEEP: begin
        // hold whatever the pins last showed
        p1_out_next    = p1_out_reg;
      end
      `PMP_MODE_STANDBY, `PMP_MODE_WATCH: begin
        // float, except a pulled-up pin which drives high;
        // the pull-up itself is switched off, the drive replaces it
        p1_out_next    = pmp_pullup(p1_dir_reg, p1_pu_reg);
        p1_oe_next     = pmp_pullup(p1_dir_reg, p1_pu_reg);
        p1_pu_out_next = 8'h00;
      end
      default: begin
        // codes 6 and 7 are unused: float every pin
        p1_out_next    = 8'h00;
        p1_oe_next     = 8'h00;
        p1_pu_out_next = 8'h00;
      end
    endcase
  end

  // pin drive registers; high impedance while in reset
  // registering the drive keeps decode glitches off the pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      p1_out_reg    <= 8'h00;
      p1_oe_reg     <= 8'h00;
      p1_pu_out_reg <= 8'h00;
      p3_out_reg    <= 8'h00;
      p3_oe_reg     <= 8'h00;
      p3_pu_out_reg <= 8'h00;
    end else begin
      // port 1 follows the mode process
      p1_out_reg    <= p1_out_next;
      p1_oe_reg     <= p1_oe_next;
      p1_pu_out_reg <= p1_pu_out_next;
      // eight bidirectional pins, pull-up on inputs only
      p3_out_reg    <= p3_data_reg & p3_dir_eff;
      p3_oe_reg     <= p3_dir_eff;
      // open-drain option: a high on this pin is released, not driven
      if (pin_opt_reg[`PMP_BIT_OPEN_DRAIN] &
          p3_data_reg[`PMP_BIT_OPEN_DRAIN]) begin
        p3_oe_reg[`PMP_BIT_OPEN_DRAIN] <= 1'b0;
      end
      // port 3 pull-ups follow the same input-only rule
      p3_pu_out_reg <= pmp_pullup(p3_dir_eff, p3_pu_reg);
    end
  end

  // peripheral inputs from port 1; idle high when not selected
  // interrupt 4 enable lives outside; software keeps it clear for trigger use
  // registered once, so a peripheral sees its pin one clock late;
  // edge sensing belongs to the peripherals, not to this block
  always @(posedge clk_i) begin
    if (rst_i) begin
      // idle level after reset matches an unselected pin
      p17_interrupt_select_reg  <= 1'b1;
      p14_interrupt_select_reg  <= 1'b1;
      tmf_reg   <= 1'b1;
      converter_ext_trigger_reg <= 1'b1;
      capg_reg  <= 1'b1;
    end else begin
      p17_interrupt_select_reg  <= p1_fsel_reg[`PMP_BIT_P17] ? p1_in_i[`PMP_BIT_P17] : 1'b1;
      tmf_reg   <= (p1_fsel_reg[`PMP_BIT_P17] & (timer_f_clock_sel_i == 3'h0)) ?
                   p1_in_i[`PMP_BIT_P17] : 1'b1;
      p14_interrupt_select_reg  <= p1_fsel_reg[`PMP_BIT_P14] ? p1_in_i[`PMP_BIT_P14] : 1'b1;
      converter_ext_trigger_reg <= (p1_fsel_reg[`PMP_BIT_P14] & converter_trigger_enable_i) ?
                   p1_in_i[`PMP_BIT_P14] : 1'b1;
      // capture input follows the pin whatever the direction bit says
      capg_reg  <= p1_fsel_reg[`PMP_BIT_P13] ? p1_in_i[`PMP_BIT_P13] : 1'b1;
    end
  end

  // every output comes straight from a flip-flop
  assign ack_o    = ack_reg;
  // upper data lanes are always zero
  assign dat_o    = {24'h000000, rdata_reg};
  assign p1_out_o = p1_out_reg;
  assign p1_oe_o  = p1_oe_reg;
  assign p1_pu_o  = p1_pu_out_reg;
  assign p3_out_o = p3_out_reg;
  assign p3_oe_o  = p3_oe_reg;
  assign p3_pu_o  = p3_pu_out_reg;
  assign p17_interrupt_select_pin_o              = p17_interrupt_select_reg;
  assign p14_interrupt_select_pin_o              = p14_interrupt_select_reg;
  assign timer_f_event_input_o   = tmf_reg;
  assign converter_ext_trigger_o = converter_ext_trigger_reg;
  assign capture_g_input_o       = capg_reg;

endmodule

/* File: testbench/pmp_port_ctrl_props.sv */
`timescale 1ns/1ps
`include "pmp_regs.vh"
module pmp_port_ctrl_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [2:0]  mode_i,
  input wire logic [7:0]  p1_out_o,
  input wire logic [7:0]  p1_oe_o,
  input wire logic [7:0]  p1_pu_o,
  input wire logic [7:0]  p3_oe_o,
  input wire logic [7:0]  p3_pu_o,
  input wire logic        p17_interrupt_select_pin_o,
  input wire logic        p14_interrupt_select_pin_o,
  input wire logic        timer_f_event_input_o,
  input wire logic        converter_ext_trigger_o,
  input wire logic        capture_g_input_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers: one pulse per request, never unasked
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
  a_dat_high_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("dat high");
  // reset must float every pin and drop the port 1 pull-ups, so reset itself is not a disable here
  a_reset_floats: assert property (disable iff (1'b0) rst_i |=> p1_oe_o == 8'h00 &&
    p3_oe_o == 8'h00 && p1_pu_o == 8'h00) else $error("reset drive");
  a_pu_not_drive: assert property ((p1_pu_o & p1_oe_o) == 8'h00 &&
    (p3_pu_o & p3_oe_o) == 8'h00) else $error("pull-up on output");
  a_standby_high: assert property (mode_i == `PMP_MODE_STANDBY &&
    $past(mode_i) == `PMP_MODE_STANDBY |-> (p1_oe_o & ~p1_out_o) == 8'h00) else $error("standby low");
  // a pin driven as gpio cannot also feed its peripheral
  a_p17_idle: assert property (mode_i == 3'h0 && $past(mode_i) == 3'h0 && p1_oe_o[7]
    |-> p17_interrupt_select_pin_o && timer_f_event_input_o) else $error("p17 leak");
  a_p13_idle: assert property (mode_i == 3'h0 && $past(mode_i) == 3'h0 && p1_oe_o[3]
    |-> capture_g_input_o) else $error("p13 leak");
  a_event_shares: assert property (!timer_f_event_input_o |-> !p17_interrupt_select_pin_o) else $error("event");
  a_trig_shares: assert property (!converter_ext_trigger_o |-> !p14_interrupt_select_pin_o) else $error("trig");
endmodule
bind pmp_port_ctrl pmp_port_ctrl_props i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .mode_i(mode_i), .p1_out_o(p1_out_o),
  .p1_oe_o(p1_oe_o), .p1_pu_o(p1_pu_o), .p3_oe_o(p3_oe_o), .p3_pu_o(p3_pu_o),
  .p17_interrupt_select_pin_o(p17_interrupt_select_pin_o), .p14_interrupt_select_pin_o(p14_interrupt_select_pin_o), .timer_f_event_input_o(timer_f_event_input_o),
  .converter_ext_trigger_o(converter_ext_trigger_o), .capture_g_input_o(capture_g_input_o));

/* File: testbench/pmp_pin_model.sv */
`timescale 1ns/1ps
module pmp_pin_model (
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_o
);
  // driven pins show the drive, released ones the pull-up or the board level
  always_comb for (int b = 0; b < 8; b++) pin_o[b] = oe_i[b] ? out_i[b] : (pu_i[b] | ext_i[b]);
endmodule

/* File: testbench/tb_pmp_port_ctrl.sv */
`timescale 1ns/1ps
`include "pmp_regs.vh"
module tb_pmp_port_ctrl;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tfe = 0, ack;
  logic [17:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic [2:0]  mode = 0, csel = 0;
  logic [7:0]  p1_ext = 0, p3_ext = 0, p1_pin, p3_pin, p1_out, p1_oe, p1_pu, p3_out, p3_oe, p3_pu, q;
  logic        p17_interrupt_select, p14_interrupt_select, tfev, trig, capg;
  int          n_fail = 0, checks_done = 0;
  always #5 clk_i = ~clk_i;
  pmp_port_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .mode_i(mode),
    .timer_f_clock_sel_i(csel), .converter_trigger_enable_i(tfe), .p1_in_i(p1_pin),
    .p1_out_o(p1_out), .p1_oe_o(p1_oe), .p1_pu_o(p1_pu), .p3_in_i(p3_pin), .p3_out_o(p3_out),
    .p3_oe_o(p3_oe), .p3_pu_o(p3_pu), .p17_interrupt_select_pin_o(p17_interrupt_select), .p14_interrupt_select_pin_o(p14_interrupt_select),
    .timer_f_event_input_o(tfev), .converter_ext_trigger_o(trig), .capture_g_input_o(capg));
  pmp_pin_model i_p1 (.oe_i(p1_oe), .out_i(p1_out), .pu_i(p1_pu), .ext_i(p1_ext), .pin_o(p1_pin));
  pmp_pin_model i_p3 (.oe_i(p3_oe), .out_i(p3_out), .pu_i(p3_pu), .ext_i(p3_ext), .pin_o(p3_pin));
  task stop_test;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled, read data taken at that edge
  // no cycle limit here: only the watchdog ends a hung wait
  task rw(input logic w, input logic [15:0] i, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, i, 2'b00, 24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  task rc(input logic [15:0] i, input logic [7:0] e);
    rw(0, i, 8'h00);
    chk(q, e);
  endtask
  task st;
    repeat (3) @(posedge clk_i);
  endtask
  task t_reset;
    rc(`PMP_IDX_PIN_OPT, 8'hD8);
    rc(`PMP_IDX_P3_DIR, 8'hFF);
    rc(`PMP_IDX_P1_DIR, 8'hFF);
    rc(`PMP_IDX_P3_PULLUP, 8'h00);
    rc(`PMP_IDX_P3_DATA, 8'h00);
    rc(16'hFFF0, 8'h00);
    chk(p1_pu, 8'h00);
  endtask
  task t_regs;
    rw(1, `PMP_IDX_P3_PULLUP, 8'h5A);
    rc(`PMP_IDX_P3_PULLUP, 8'h5A);
    chk(p3_pu, 8'h5A);
    rw(1, `PMP_IDX_P3_PULLUP, 8'h00);
    rw(1, `PMP_IDX_P3_FSEL, 8'hC7);
    rc(`PMP_IDX_P3_FSEL, 8'hC7);
    rw(1, `PMP_IDX_P3_FSEL, 8'h00);
    rw(1, `PMP_IDX_PIN_OPT, 8'h00);
    rc(`PMP_IDX_PIN_OPT, 8'hD8);
  endtask
  task t_p3;
    p3_ext <= 8'h3C;
    rw(1, `PMP_IDX_P3_DIR, 8'h0F);
    rw(1, `PMP_IDX_P3_DATA, 8'hA5);
    st;
    rc(`PMP_IDX_P3_DATA, 8'h35);
    chk(p3_oe, 8'h0F);
    chk(p3_out & 8'h0F, 8'h05);
    // open-drain option on pin 5: a high is released, a low driven
    rw(1, `PMP_IDX_PIN_OPT, 8'h20);
    rc(`PMP_IDX_PIN_OPT, 8'hF8);
    rw(1, `PMP_IDX_P3_DIR, 8'h2F);
    rw(1, `PMP_IDX_P3_DATA, 8'h20);
    st;
    chk(p3_oe, 8'h0F);
    rw(1, `PMP_IDX_P3_DATA, 8'h00);
    st;
    chk(p3_oe, 8'h2F);
    rw(1, `PMP_IDX_PIN_OPT, 8'h00);
  endtask
  task t_p1;
    p1_ext <= 8'h10;
    rw(1, `PMP_IDX_P1_DIR, 8'h88);
    rw(1, `PMP_IDX_P1_DATA, 8'h80);
    st;
    rc(`PMP_IDX_P1_DATA, 8'h90);
    chk(p1_oe & 8'h98, 8'h88);
    rw(1, `PMP_IDX_P1_PULLUP, 8'h98);
    st;
    chk(p1_pu & 8'h98, 8'h10);
    rw(1, `PMP_IDX_P1_DIR, 8'h00);
    st;
    chk(p1_pu & 8'h98, 8'h98);
  endtask
  task t_modes;
    mode <= `PMP_MODE_STANDBY;
    st;
    chk(p1_oe & p1_out & 8'h98, 8'h98);
    mode <= `PMP_MODE_ACTIVE;
    rw(1, `PMP_IDX_P1_PULLUP, 8'h00);
    rw(1, `PMP_IDX_P1_DIR, 8'h98);
    rw(1, `PMP_IDX_P1_DATA, 8'h18);
    st;
    mode <= `PMP_MODE_SLEEP;
    rw(1, `PMP_IDX_P1_DATA, 8'h80);
    st;
    chk(p1_out & 8'h98, 8'h18);
    mode <= `PMP_MODE_ACTIVE;
    st;
    chk(p1_out & 8'h98, 8'h80);
    mode <= `PMP_MODE_WATCH;
    st;
    chk(p1_oe & 8'h98, 8'h00);
    mode <= `PMP_MODE_SUBACTIVE;
    st;
    chk(p1_oe & 8'h98, 8'h98);
    mode <= `PMP_MODE_SUBSLEEP;
    rw(1, `PMP_IDX_P1_DIR, 8'h00);
    st;
    chk(p1_oe & 8'h98, 8'h98);
    mode <= `PMP_MODE_ACTIVE;
    st;
    chk(p1_oe & 8'h98, 8'h00);
    rw(1, `PMP_IDX_P1_DIR, 8'h98);
  endtask
  // selected pins turn into inputs feeding irq, timer and trigger lines
  task t_sel;
    p1_ext <= 8'h00;
    rw(1, `PMP_IDX_P1_FSEL, 8'h98);
    st;
    chk(p1_oe & 8'h98, 8'h00);
    chk({p17_interrupt_select, tfev, p14_interrupt_select, trig, capg}, 8'h02);
    csel <= 3'h1;
    tfe <= 1'b1; // trigger use: p14_interrupt_select enable kept clear outside
    st;
    chk({p17_interrupt_select, tfev, p14_interrupt_select, trig, capg}, 8'h08);
    p1_ext <= 8'h98;
    st;
    chk({p17_interrupt_select, tfev, p14_interrupt_select, trig, capg}, 8'h1F);
    rw(1, `PMP_IDX_P1_PULLUP, 8'h98);
    st;
    chk(p1_pu & 8'h98, 8'h00);
    rw(1, `PMP_IDX_P1_FSEL, 8'h00);
    st;
    chk(p1_oe & 8'h98, 8'h98);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_regs;
    t_p3;
    t_p1;
    t_modes;
    t_sel;
    stop_test;
  end
  // watchdog far beyond the 170 or so cycles the run needs
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
endmodule
